// *** hw/tcs_counter.sv ***
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "tcs_regs.svh"
// Overview of operation
// [R1] On the chosen reference edge the counter is loaded with the start value.
// [R2] The reference may be a rising or falling aux input edge or a rising zero-mark edge.
// [R3] A qualified option takes zero-mark rises only while the chosen aux input equals the qualifier bit level.
// [R4] With hysteresis set, an output cannot switch again while the count stays in the band.
// [R5] The same suppression applies when a counting limit lies inside the band.
// [R6] Supply loss and output faults raise a diagnostic interrupt only when enabled.
// [R7] The interference filter covers the encoder inputs and the aux inputs.
// [R8] In isochronous mode processing follows the common system cycle.
// [R9] Compare outputs switch at once, never waiting for a cycle boundary.
// [R10] An aux input change acts at once and updates its live status bit.
// [R11] Control written in a cycle takes effect at the next internal processing tick, except the diagnostic enable, which acts at once.
// [R12] Count and status are latched at the capture instant for readback.
// [R13] In up/down mode the first input counts up and the second counts down.
// [R14] The start value is clamped into the counting limits.
// [R15] The encoder delivers quadrature signals and an optional zero mark.
// [R16] A suppressed output re-arms only after the count leaves the band.
// [R17] Sync edges come from filtered inputs and load within one processing tick.
module tcs_counter
  import tcs_pkg::*;
#(
  parameter int CW = 25
)
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        encA,
  input  wire logic        encB,
  input  wire logic        encZero,
  input  wire logic        aux_input_0,
  input  wire logic        aux_input_1,
  input  wire logic        aux_input_2,
  input  wire logic        supplyLost,
  input  wire logic        outputFault,
  input  wire logic        isoCapture,
  output logic             compare_output_0,
  output logic             compare_output_1,
  output logic             irq
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0]   ctrl_q;
  logic [CW-1:0] start_q, loLim_q, hiLim_q, hyst_q;
  logic [CW-1:0] cmp_q [2];
  logic [15:0]   filt_q, cycle_q;
  logic [CW-1:0] count_q, cntCap_q;
  tcs_status_t   statCap_q;
  logic [`TCS_IRQ_W-1:0] irqStat_q, irqMask_q;
  logic [31:0]   prdata_q;
  logic          pready_q, pslverr_q, irq_q, syncDone_q;
  logic [1:0]    dq_q, armed_q;
  logic [15:0]   tickCnt_q;
  logic [31:0]   ctrlAct_q;
  logic [CW-1:0] startAct_q;
  logic          a_q, b_q, z_q, di_q0, di_q1, di_q2, sup_q, flt_q, iso_q;
  logic          syncPend_q;

  // ----------------------------------------
  // Input filtering
  // ----------------------------------------
  tcs_pins_t rawPins, fPins;
  assign rawPins = '{a: encA, b: encB, n: encZero,
                     di: {aux_input_2, aux_input_1, aux_input_0}};
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : gFilt
      tcs_filter uFilt (                                            // R7
        .sys_clk      (sys_clk),
        .rst          (rst),
        .pinIn        (rawPins[gi]),
        .stableCycles (filt_q),
        .pinOut       (fPins[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire       wrEn   = psel && penable && pwrite && pready_q;
  wire       rdEn   = psel && penable && !pwrite;
  wire [11:0] off   = {paddr[11:2], 2'b00};
  wire       hitOk  = off <= `TCS_IRQMASK_OFF;
  wire       wrCtrl = wrEn && off == `TCS_CTRL_OFF;
  wire       wrIrqC = wrEn && off == `TCS_IRQSTAT_OFF;

  // ----------------------------------------
  // Processing tick
  // ----------------------------------------
  tcs_enc_t  encMode;
  tcs_sync_t syncMode;
  assign encMode  = tcs_enc_t'(ctrlAct_q[`TCS_CTRL_ENC_LSB +: 2]);
  assign syncMode = tcs_sync_t'(ctrlAct_q[`TCS_CTRL_SYNC_LSB +: 3]);
  wire [1:0] diSel   = ctrlAct_q[`TCS_CTRL_DISEL_LSB +: 2];
  wire       isoMode = ctrlAct_q[`TCS_CTRL_ISO_BIT];
  logic      fPinsIso;
  assign fPinsIso = isoCapture;
  wire       isoRise = fPinsIso && !iso_q;
  wire       freeTick = tickCnt_q >= cycle_q;
  wire       tick     = isoMode ? isoRise : freeTick;              // R8

  // ----------------------------------------
  // Edge detection and counting
  // ----------------------------------------
  wire [2:0] diPrev  = {di_q2, di_q1, di_q0};
  wire       diSelNow  = fPins.di[diSel];
  wire       diSelPrev = diPrev[diSel];
  wire       zeroRise  = fPins.n && !z_q;
  wire       syncEdge =                                             // R2 R17
      (syncMode == TCS_SYNC_DIRISE && diSelNow && !diSelPrev) ||
      (syncMode == TCS_SYNC_DIFALL && !diSelNow && diSelPrev) ||
      (syncMode == TCS_SYNC_ZERO && zeroRise) ||
      (syncMode == TCS_SYNC_ZQUAL && zeroRise &&                     // R3
       diSelNow == ctrlAct_q[`TCS_CTRL_QUAL_BIT]);
  wire aRise = fPins.a && !a_q;
  wire aFall = !fPins.a && a_q;
  wire bRise = fPins.b && !b_q;
  wire bFall = !fPins.b && b_q;
  logic up, dn;
  always_comb
  begin
    up = 1'b0;
    dn = 1'b0;
    case (encMode)
      TCS_ENC_QUAD:
      begin
        up = (aRise && !fPins.b) || (aFall && fPins.b) ||
             (bRise && fPins.a) || (bFall && !fPins.a);
        dn = (aRise && fPins.b) || (aFall && !fPins.b) ||
             (bRise && !fPins.a) || (bFall && fPins.a);
      end
      TCS_ENC_UPDOWN:
      begin
        up = aRise;                                                 // R13
        dn = bRise;                                                 // R13
      end
      TCS_ENC_PULSE: up = aRise;
      TCS_ENC_DIR:
      begin
        up = aRise && !fPins.b;
        dn = aRise && fPins.b;
      end
      default: ;
    endcase
  end
  wire [CW-1:0] startClamped =                                      // R14
      start_q < loLim_q ? loLim_q : (start_q > hiLim_q ? hiLim_q : start_q);
  logic [CW-1:0] count_d;
  always_comb
  begin
    count_d = count_q;
    if (syncPend_q && tick)
      count_d = startAct_q;                                         // R1 R17
    else if (up && !dn)
      count_d = count_q >= hiLim_q ? loLim_q : count_q + 1'b1;
    else if (dn && !up)
      count_d = count_q <= loLim_q ? hiLim_q : count_q - 1'b1;
  end

  // ----------------------------------------
  // Compare outputs with hysteresis
  // ----------------------------------------
  logic [1:0] dq_d, armed_d;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : gCmp
      wire [CW-1:0] ref_v  = cmp_q[gi];
      wire          inBand = (count_q + hyst_q >= ref_v) &&
                             (count_q <= ref_v + hyst_q);           // R4
      wire          atLim  = (count_q <= loLim_q + hyst_q) ||
                             (count_q + hyst_q >= hiLim_q);         // R5
      wire          cond   = count_q >= ref_v;
      wire          en     = ctrlAct_q[`TCS_CTRL_CMPEN_LSB + gi];
      wire          block  = (hyst_q != '0) && (inBand || atLim);
      assign dq_d[gi]    = !en ? 1'b0 :
                           (cond != dq_q[gi] && (armed_q[gi] || hyst_q == '0))
                           ? cond : dq_q[gi];                       // R9
      assign armed_d[gi] = (dq_d[gi] != dq_q[gi]) ? !block :
                           (!block ? 1'b1 : armed_q[gi]);           // R16
    end
  endgenerate

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  wire diagEn = ctrl_q[`TCS_CTRL_DIAGEN_BIT];
  wire supRise = supplyLost && !sup_q;
  wire fltRise = outputFault && !flt_q;
  wire [`TCS_IRQ_W-1:0] evt = {syncPend_q && tick,
                               diagEn && fltRise, diagEn && supRise}; // R6
  wire [`TCS_IRQ_W-1:0] irqStat_d =
      (irqStat_q & ~(wrIrqC ? pwdata[`TCS_IRQ_W-1:0] : '0)) | evt;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  tcs_status_t liveStat;
  assign liveStat = '{dq: dq_q, di: fPins.di, syncDone: syncDone_q,
                      dir: up};                                     // R10
  logic [31:0] rdMux;
  always_comb
  begin
    case (off)
      `TCS_CTRL_OFF:    rdMux = ctrl_q;
      `TCS_START_OFF:   rdMux = 32'(start_q);
      `TCS_LOLIM_OFF:   rdMux = 32'(loLim_q);
      `TCS_HILIM_OFF:   rdMux = 32'(hiLim_q);
      `TCS_CMP0_OFF:    rdMux = 32'(cmp_q[0]);
      `TCS_CMP1_OFF:    rdMux = 32'(cmp_q[1]);
      `TCS_HYST_OFF:    rdMux = 32'(hyst_q);
      `TCS_FILT_OFF:    rdMux = {16'h0, filt_q};
      `TCS_CYCLE_OFF:   rdMux = {16'h0, cycle_q};
      `TCS_CNTCAP_OFF:  rdMux = 32'(cntCap_q);
      `TCS_STATCAP_OFF: rdMux = 32'(statCap_q);
      `TCS_LIVE_OFF:    rdMux = 32'(liveStat);
      `TCS_IRQSTAT_OFF: rdMux = 32'(irqStat_q);
      `TCS_IRQMASK_OFF: rdMux = 32'(irqMask_q);
      default:          rdMux = 32'h0;
    endcase
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      ctrl_q    <= `TCS_CTRL_RST;
      start_q   <= '0;
      loLim_q   <= '0;
      hiLim_q   <= CW'(`TCS_HILIM_RST);
      cmp_q[0]  <= '0;
      cmp_q[1]  <= '0;
      hyst_q    <= '0;
      filt_q    <= `TCS_FILT_RST;
      cycle_q   <= `TCS_CYCLE_RST;
      irqMask_q <= '0;
    end
    else if (wrEn)
      case (off)
        `TCS_CTRL_OFF:    ctrl_q    <= pwdata;
        `TCS_START_OFF:   start_q   <= pwdata[CW-1:0];
        `TCS_LOLIM_OFF:   loLim_q   <= pwdata[CW-1:0];
        `TCS_HILIM_OFF:   hiLim_q   <= pwdata[CW-1:0];
        `TCS_CMP0_OFF:    cmp_q[0]  <= pwdata[CW-1:0];
        `TCS_CMP1_OFF:    cmp_q[1]  <= pwdata[CW-1:0];
        `TCS_HYST_OFF:    hyst_q    <= pwdata[CW-1:0];
        `TCS_FILT_OFF:    filt_q    <= pwdata[15:0];
        `TCS_CYCLE_OFF:   cycle_q   <= pwdata[15:0];
        `TCS_IRQMASK_OFF: irqMask_q <= pwdata[`TCS_IRQ_W-1:0];
        default: ;
      endcase

  // ----------------------------------------
  // Core state
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      ctrlAct_q  <= `TCS_CTRL_RST;
      startAct_q <= '0;
      tickCnt_q  <= 16'h0;
      count_q    <= '0;
      cntCap_q   <= '0;
      statCap_q  <= '0;
      syncPend_q <= 1'b0;
      syncDone_q <= 1'b0;
      {a_q, b_q, z_q, di_q0, di_q1, di_q2} <= 6'h0;
      {sup_q, flt_q, iso_q} <= 3'h0;
      dq_q       <= 2'h0;
      armed_q    <= 2'h3;
      irqStat_q  <= '0;
      irq_q      <= 1'b0;
      prdata_q   <= 32'h0;
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
    end
    else
    begin
      tickCnt_q <= tick || freeTick ? 16'h0 : tickCnt_q + 16'h1;
      if (tick)
      begin
        ctrlAct_q  <= ctrl_q;                                       // R11
        startAct_q <= startClamped;                                 // R11
        cntCap_q   <= count_q;                                      // R12
        statCap_q  <= liveStat;                                     // R12
      end
      syncPend_q <= syncEdge || (syncPend_q && !tick);
      syncDone_q <= (syncPend_q && tick) || (syncDone_q && !wrCtrl);
      count_q    <= count_d;
      {a_q, b_q, z_q} <= {fPins.a, fPins.b, fPins.n};
      {di_q2, di_q1, di_q0} <= fPins.di;
      {sup_q, flt_q, iso_q} <= {supplyLost, outputFault, fPinsIso};
      dq_q       <= dq_d;
      armed_q    <= armed_d;
      irqStat_q  <= irqStat_d;
      irq_q      <= |(irqStat_d & irqMask_q);
      prdata_q   <= rdEn && !pready_q ? rdMux : prdata_q;
      pready_q   <= psel && penable && !pready_q;
      pslverr_q  <= psel && penable && !pready_q && !hitOk;
    end

  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign compare_output_0 = dq_q[0];
  assign compare_output_1 = dq_q[1];
  assign irq              = irq_q;
endmodule

// *** hw/tcs_filter.sv ***
`timescale 1ns/1ps
`include "tcs_regs.svh"
// Three-stage synchroniser plus stability filter for one pin
module tcs_filter
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        pinIn,
  input  wire logic [15:0] stableCycles,
  output logic             pinOut
);
  logic [2:0]  sync_q;
  logic [15:0] cnt_q;
  logic        out_q;
  wire         agreed  = sync_q[2] == sync_q[1];
  wire         differs = agreed && (sync_q[1] != out_q);

  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      sync_q <= 3'h0;
      cnt_q  <= 16'h0;
      out_q  <= 1'b0;
    end
    else
    begin
      sync_q <= {sync_q[1:0], pinIn};
      if (!differs)
        cnt_q <= 16'h0;
      else if (cnt_q >= stableCycles)
      begin
        out_q <= sync_q[2];
        cnt_q <= 16'h0;
      end
      else
        cnt_q <= cnt_q + 16'h1;
    end
  assign pinOut = out_q;
endmodule

// *** hw/tcs_pkg.sv ***
package tcs_pkg;
  typedef enum logic [1:0] {
    TCS_ENC_QUAD   = 2'b00,
    TCS_ENC_UPDOWN = 2'b01,
    TCS_ENC_PULSE  = 2'b10,
    TCS_ENC_DIR    = 2'b11
  } tcs_enc_t;
  typedef enum logic [2:0] {
    TCS_SYNC_OFF    = 3'b000,
    TCS_SYNC_DIRISE = 3'b001,
    TCS_SYNC_DIFALL = 3'b010,
    TCS_SYNC_ZERO   = 3'b011,
    TCS_SYNC_ZQUAL  = 3'b100
  } tcs_sync_t;
  typedef struct packed {
    logic a;
    logic b;
    logic n;
    logic [2:0] di;
  } tcs_pins_t;
  typedef struct packed {
    logic [1:0] dq;
    logic [2:0] di;
    logic       syncDone;
    logic       dir;
  } tcs_status_t;
endpackage

// *** hw/tcs_regs.svh ***
`ifndef TCS_REGS_SVH
`define TCS_REGS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TCS_CTRL_OFF      12'h000
`define TCS_START_OFF     12'h004
`define TCS_LOLIM_OFF     12'h008
`define TCS_HILIM_OFF     12'h00c
`define TCS_CMP0_OFF      12'h010
`define TCS_CMP1_OFF      12'h014
`define TCS_HYST_OFF      12'h018
`define TCS_FILT_OFF      12'h01c
`define TCS_CYCLE_OFF     12'h020
`define TCS_CNTCAP_OFF    12'h024
`define TCS_STATCAP_OFF   12'h028
`define TCS_LIVE_OFF      12'h02c
`define TCS_IRQSTAT_OFF   12'h030
`define TCS_IRQMASK_OFF   12'h034
// ----------------------------------------
// Control field positions
// ----------------------------------------
`define TCS_CTRL_ENC_LSB  0
`define TCS_CTRL_SYNC_LSB 2
`define TCS_CTRL_DISEL_LSB 5
`define TCS_CTRL_QUAL_BIT 7
`define TCS_CTRL_ISO_BIT  8
`define TCS_CTRL_CMPEN_LSB 9
`define TCS_CTRL_DIAGEN_BIT 11
// ----------------------------------------
// Interrupt bits
// ----------------------------------------
`define TCS_IRQ_SUPPLY    0
`define TCS_IRQ_OUTFAULT  1
`define TCS_IRQ_SYNC      2
`define TCS_IRQ_W         3
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define TCS_CTRL_RST      32'h0000_0000
`define TCS_HILIM_RST     32'h01ff_ffff
`define TCS_FILT_RST      16'h0190
`define TCS_CYCLE_RST     16'h00c8
`define TCS_TICK_NS       5
`endif

// *** test/tcs_counter_monitor.sv ***
`timescale 1ns/1ps
`include "tcs_regs.svh"
module tcs_counter_monitor
#(
  parameter int CW = 25
)
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        compare_output_0,
  input wire logic        irq
);
  // --------
  // Shadows of bus writes
  // --------
  logic [2:0] mask_q;
  logic       diagEn_q;
  logic       cmpEn_q;
  wire        wrDone = psel && penable && pwrite && pready;
  wire        maskWr = wrDone && (paddr == `TCS_IRQMASK_OFF);
  wire        ctrlWr = wrDone && (paddr == `TCS_CTRL_OFF);
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      mask_q   <= 3'h0;
      diagEn_q <= 1'b0;
      cmpEn_q  <= 1'b0;
    end
    else
    begin
      if (maskWr)
        mask_q <= pwdata[2:0];
      if (ctrlWr)
        diagEn_q <= pwdata[11];
      if (ctrlWr)
        cmpEn_q <= pwdata[9];
    end
  end
  // --------
  // Properties
  // --------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  property p_take;
    s_access |-> ##[1:2] pready;
  endproperty
  a_take: assert property (p_take) else $error("access not answered");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_only_access;
    pready |-> psel && penable;
  endproperty
  a_only_access: assert property (p_only_access) else $error("ready outside access");
  property p_err;
    pready |-> (pslverr == (paddr > 12'h034));
  endproperty
  a_err: assert property (p_err) else $error("error flag wrong for offset");
  property p_err_zero;
    pready && pslverr && !pwrite |-> prdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("unmapped read not zero");
  property p_rst_quiet;
    $fell(rst) |-> !pready && !irq && !compare_output_0;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("output active after reset");
  property p_irq_mask;
    irq |-> mask_q != 3'h0;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq with all masked");
  property p_irq_rise;
    $rose(irq) |-> diagEn_q || mask_q[2];
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("diag irq not enabled");
  property p_cmp_rise;
    $rose(compare_output_0) |-> cmpEn_q;
  endproperty
  a_cmp_rise: assert property (p_cmp_rise) else $error("output rose while disabled");
endmodule
bind tcs_counter tcs_counter_monitor #(.CW(CW)) u_mon
(
  .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .compare_output_0, .irq
);

// *** test/tcs_enc_model.sv ***
`timescale 1ns/1ps
// --------
// Pulse encoder, one pulse per request
// --------
module tcs_enc_model
(
  input wire logic       sys_clk,
  input wire logic       upReq,
  input wire logic       dnReq,
  input wire logic       zeroReq,
  input wire logic [7:0] hold,
  output logic           encA,
  output logic           encB,
  output logic           encZero,
  output logic           busy
);
  initial
  begin
    {encA, encB, encZero, busy} = 4'h0;
    forever
    begin
      @(posedge sys_clk);
      if (upReq || dnReq || zeroReq)
      begin
        busy    <= 1'b1;
        encA    <= upReq;
        encB    <= dnReq;
        encZero <= zeroReq;
        repeat (hold) @(posedge sys_clk);
        {encA, encB, encZero} <= 3'h0;
        repeat (hold) @(posedge sys_clk);
        busy <= 1'b0;
      end
    end
  end
endmodule

// *** test/test_tcs_counter.sv ***
`timescale 1ns/1ps
`include "tcs_regs.svh"
module test_tcs_counter
  import tcs_pkg::*;
;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic        cmp0, cmp1, up, dn, zr, busy, encA, encB, encZero;
  logic        supplyLost, outputFault, isoCapture;
  logic [2:0]  aux, r;
  logic [7:0]  hold;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d, c;
  logic [31:0] expQ[$], mskQ[$];
  int          mismatches, checks, cyc;
  tcs_counter #(.CW(25)) DUT
  (
    .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .encA, .encB, .encZero, .aux_input_0(aux[0]),
    .aux_input_1(aux[1]), .aux_input_2(aux[2]), .supplyLost, .outputFault,
    .isoCapture, .compare_output_0(cmp0), .compare_output_1(cmp1), .irq
  );
  tcs_enc_model PEER
  (
    .sys_clk, .upReq(up), .dnReq(dn), .zeroReq(zr), .hold, .encA, .encB,
    .encZero, .busy
  );
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // --------
  // Checking and closing
  // --------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      stop_test();
    end
    else if (psel && penable && pready === 1'b1 && !pwrite)
      check(prdata & mskQ.pop_front(), expQ.pop_front());
  end
  // --------
  // Bus and pin drivers
  // --------
  task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, v};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    {psel, penable} <= 2'h0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffff_ffff);
    expQ.push_back(e);
    mskQ.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask
  task wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task pin(input logic s, input logic e);
    check({31'h0, s}, {31'h0, e});
  endtask
  task step(input int kind, input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      {up, dn, zr} <= {kind == 0, kind == 1, kind == 2};
      @(posedge sys_clk);
      {up, dn, zr} <= 3'h0;
      @(posedge sys_clk);
      while (busy) @(posedge sys_clk);
    end
    wt(30);
  endtask
  function automatic logic [31:0] ctl(input tcs_sync_t s, input logic [3:0] hi);
    return {20'h0, hi, 1'b1, 2'h1, s, TCS_ENC_UPDOWN};
  endfunction
  task syncChk(input logic [31:0] cv, input logic [31:0] s, input logic z, input logic e);
    wr(`TCS_START_OFF, s);
    wr(`TCS_CTRL_OFF, cv);
    wt(20);
    if (z)
      step(2, 1);
    else
      aux[1] <= ~aux[1];
    wt(30);
    pin(cmp0, e);
  endtask
  // --------
  // Main sequence
  // --------
  initial
  begin
    void'($urandom(12));
    {psel, penable, pwrite, up, dn, zr, supplyLost, outputFault, isoCapture} = 9'h0;
    {paddr, pwdata, aux, hold, rst} = {12'h0, 32'h0, 3'h0, 8'ha, 1'b1};
    wt(20);
    rst <= 1'b0;
    rd(`TCS_CTRL_OFF, `TCS_CTRL_RST);
    rd(`TCS_HILIM_OFF, `TCS_HILIM_RST);
    rd(`TCS_FILT_OFF, {16'h0, `TCS_FILT_RST});
    rd(`TCS_CYCLE_OFF, {16'h0, `TCS_CYCLE_RST});
    rd(`TCS_IRQMASK_OFF, 32'h0);
    rd(12'h038, 32'h0);
    wr(`TCS_FILT_OFF, 32'h2);
    wr(`TCS_CYCLE_OFF, 32'h2);
    d = $urandom;
    wr(`TCS_CMP1_OFF, d);
    rd(`TCS_CMP1_OFF, d & 32'h01ff_ffff);
    wr(`TCS_CMP0_OFF, 32'hd);
    wr(`TCS_CMP1_OFF, 32'h9);
    syncChk(ctl(TCS_SYNC_DIRISE, 4'h6), 32'ha, 1'b0, 1'b0);
    pin(cmp1, 1'b1);
    step(0, 3);
    pin(cmp0, 1'b1);
    step(1, 1);
    pin(cmp0, 1'b0);
    syncChk(ctl(TCS_SYNC_DIFALL, 4'h2), 32'h14, 1'b0, 1'b1);
    syncChk(ctl(TCS_SYNC_ZERO, 4'h2), 32'h5, 1'b1, 1'b0);
    c = ctl(TCS_SYNC_ZQUAL, 4'h2);
    syncChk(c, 32'h14, 1'b1, 1'b0);
    aux[1] <= 1'b1;
    syncChk(c, 32'h14, 1'b1, 1'b1);
    wr(`TCS_HILIM_OFF, 32'h1e);
    wr(`TCS_CMP0_OFF, 32'h1f);
    syncChk(c, 32'h28, 1'b1, 1'b0);
    wr(`TCS_HILIM_OFF, `TCS_HILIM_RST);
    wr(`TCS_CMP0_OFF, 32'hd);
    wr(`TCS_HYST_OFF, 32'h3);
    hold <= 8'h1e;
    syncChk(c, 32'h5, 1'b1, 1'b0);
    step(0, 8);
    pin(cmp0, 1'b1);
    step(1, 1);
    pin(cmp0, 1'b1);
    step(1, 4);
    pin(cmp0, 1'b0);
    wr(`TCS_HYST_OFF, 32'h0);
    wr(`TCS_IRQSTAT_OFF, 32'h7);
    wr(`TCS_IRQMASK_OFF, 32'h7);
    supplyLost <= 1'b1;
    wt(3);
    supplyLost <= 1'b0;
    wt(10);
    pin(irq, 1'b0);
    rd(`TCS_IRQSTAT_OFF, 32'h0);
    wr(`TCS_CTRL_OFF, ctl(TCS_SYNC_ZQUAL, 4'ha));
    wt(20);
    supplyLost <= 1'b1;
    outputFault <= 1'b1;
    wt(10);
    pin(irq, 1'b1);
    rd(`TCS_IRQSTAT_OFF, 32'h3);
    wr(`TCS_IRQSTAT_OFF, 32'h1);
    rd(`TCS_IRQSTAT_OFF, 32'h2);
    wr(`TCS_IRQMASK_OFF, 32'h1);
    wt(5);
    pin(irq, 1'b0);
    wr(`TCS_IRQSTAT_OFF, 32'h2);
    rd(`TCS_IRQSTAT_OFF, 32'h0);
    wr(`TCS_CMP0_OFF, 32'h5);
    wr(`TCS_CTRL_OFF, ctl(TCS_SYNC_ZQUAL, 4'hb));
    r = 3'($urandom);
    aux <= r;
    wt(20);
    isoCapture <= 1'b1;
    wt(5);
    aux <= ~r;
    isoCapture <= 1'b0;
    wt(20);
    rd(`TCS_LIVE_OFF, {27'h0, ~r, 2'h0}, 32'h1c);
    rd(`TCS_STATCAP_OFF, {27'h0, r, 2'h0}, 32'h1c);
    wr(`TCS_CTRL_OFF, ctl(TCS_SYNC_ZQUAL, 4'h9));
    wt(20);
    pin(cmp0, 1'b1);
    isoCapture <= 1'b1;
    wt(20);
    pin(cmp0, 1'b0);
    rd(`TCS_STATCAP_OFF, {27'h0, ~r, 2'h0}, 32'h1c);
    stop_test();
  end
endmodule
